// [ssp_regs.v]
// switch status and power budget register bank, axi4-lite slave
//
// Behaviour
// - eight 32-bit power budget value words
// - budget words writable while unlock bit set
// - unlock clear: budget writes silently discarded
// - operating mode read-only at bits 2:0
// - bit 5 shows latched downstream clock strap
// - bit 6 shows latched upstream clock strap
// - bit 7 shows latched smbus slow strap
// - bit 8 shows latched refclk mode strap
// - bit 9 shows latched reset hold strap
// - lock state bits 22:20, resets to zero
// - marker 31:28 rw, survives hot reset
// - unlock is control bit 4
// - read-back returns selected word, zero above 7
// - reset hold keeps core logic in reset
`timescale 1ns/10ps
`include "ssp_consts.vh"
module ssp_regs (
  // clock and resets
  input  wire        i_clock,
  input  wire        i_rst,
  input  wire        i_hot_rst,
  // straps, sampled while fundamental reset is high
  input  wire [2:0]  i_mode_pins,
  input  wire        i_ds_clk_strap,
  input  wire        i_us_clk_strap,
  input  wire        i_smb_slow_strap,
  input  wire        i_refclk_strap,
  input  wire        i_hold_strap,
  // lock state from the upstream port
  input  wire [2:0]  i_lock_state,
  // core reset hold out
  output wire        o_core_hold,
  // axi4-lite write address
  input  wire [11:0] i_s_axi_awaddr,
  input  wire        i_s_axi_awvalid,
  output wire        o_s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] i_s_axi_wdata,
  input  wire [3:0]  i_s_axi_wstrb,
  input  wire        i_s_axi_wvalid,
  output wire        o_s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  o_s_axi_bresp,
  output reg         o_s_axi_bvalid,
  input  wire        i_s_axi_bready,
  // axi4-lite read address
  input  wire [11:0] i_s_axi_araddr,
  input  wire        i_s_axi_arvalid,
  output wire        o_s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] o_s_axi_rdata,
  output reg  [1:0]  o_s_axi_rresp,
  output reg         o_s_axi_rvalid,
  input  wire        i_s_axi_rready
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg [2:0]  op_mode;
  reg        ds_clk;
  reg        us_clk;
  reg        smb_slow;
  reg        refclk_mode;
  reg        hold_strap;
  reg        strap_pend;
  reg [3:0]  marker;
  reg        budget_value_unlock;
  reg        hold_ctl;
  reg [7:0]  budget_data_select;
  reg [2:0]  upstream_lock_state;
  reg        aw_held;
  reg [11:0] aw_addr;
  reg        w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg        rd_pend;
  reg [11:0] rd_addr;

  wire [31:0] mem_rd_data;
  wire [31:0] mem_rb_data;

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  // async reset may only load constants, so the straps are taken by
  // clocked edges while reset is high and frozen at the release
  always @(posedge i_clock) begin
    if (i_rst) begin
      op_mode     <= i_mode_pins;
      ds_clk      <= i_ds_clk_strap;
      us_clk      <= i_us_clk_strap;
      smb_slow    <= i_smb_slow_strap;
      refclk_mode <= i_refclk_strap;
      hold_strap  <= i_hold_strap;
    end
  end

  // ---------------------------------------------------------------
  // lock state sample
  // ---------------------------------------------------------------
  // one register stage; the code is a level that may move any cycle
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      upstream_lock_state <= `SSP_LOCK_RESET;
    end else begin
      upstream_lock_state <= i_lock_state;
    end
  end

  // ---------------------------------------------------------------
  // write channel: address and data accepted in either order
  // ---------------------------------------------------------------
  // a new address may be taken while the previous answer still
  // waits for bready; wr_go then stalls until bvalid has dropped,
  // so only one response is ever outstanding
  wire wr_go = aw_held && w_held && !o_s_axi_bvalid;
  assign o_s_axi_awready = !aw_held;
  assign o_s_axi_wready  = !w_held;

  wire wr_budget = (aw_addr >= `SSP_OFF_BUDGET_BASE) &&
                   (aw_addr <= `SSP_OFF_BUDGET_LAST);
  wire wr_mapped = wr_budget || aw_addr == `SSP_OFF_STATUS ||
                   aw_addr == `SSP_OFF_CONTROL ||
                   aw_addr == `SSP_OFF_BUDGET_SELECT ||
                   aw_addr == `SSP_OFF_BUDGET_READ ||
                   aw_addr == `SSP_OFF_LOCK;
  // locked writes are dropped yet still answered okay
  wire mem_wr_en = wr_go && wr_budget && budget_value_unlock;

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      aw_held        <= 1'b0;
      aw_addr        <= 12'h000;
      w_held         <= 1'b0;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= `SSP_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {i_s_axi_awaddr[11:2], 2'b00};
      end
      if (i_s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= wr_mapped ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // marker: cleared only by fundamental reset
  // ---------------------------------------------------------------
  // only byte lane 3 reaches the marker; other status lanes are fixed
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      marker <= `SSP_MARKER_RESET;
    end else if (wr_go && aw_addr == `SSP_OFF_STATUS && w_strb[3]) begin
      marker <= w_data[`SSP_MARKER_MSB:`SSP_MARKER_LSB];
    end
  end

  // ---------------------------------------------------------------
  // control and select; control bits survive hot reset, select clears on it
  // ---------------------------------------------------------------
  // strap_pend marks the first cycle after fundamental reset; in it
  // the hold strap drives the hold output directly, so the core is
  // held from the release edge on, before the control copy is loaded
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      strap_pend <= 1'b1;
    end else begin
      strap_pend <= 1'b0;
    end
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      budget_value_unlock <= 1'b0;
      hold_ctl            <= 1'b0;
      budget_data_select  <= `SSP_SELECT_RESET;
    end else begin
      if (strap_pend) begin
        hold_ctl <= hold_strap;
      end else if (wr_go && aw_addr == `SSP_OFF_CONTROL && w_strb[0]) begin
        budget_value_unlock <= w_data[`SSP_UNLOCK_BIT];
        hold_ctl            <= w_data[2];
      end
      if (i_hot_rst) begin
        budget_data_select <= `SSP_SELECT_RESET;
      end else if (wr_go && aw_addr == `SSP_OFF_BUDGET_SELECT &&
                   w_strb[0]) begin
        budget_data_select <= w_data[7:0];
      end
    end
  end

  // hold keeps core (not this slave) in reset; seeded from strap.
  // the strap term covers the cycle before hold_ctl is loaded, so
  // no one-cycle release glitch reaches the core at reset exit
  assign o_core_hold = hold_ctl || (strap_pend && hold_strap);

  // ---------------------------------------------------------------
  // budget word store
  // ---------------------------------------------------------------
  // no reset on the store: the words are sticky and undefined until
  // software or an initialisation sequence loads them
  ssp_budget_mem u_mem (
    .i_clock   (i_clock),
    .i_wr_en   (mem_wr_en),
    .i_wr_addr (aw_addr[4:2]),
    .i_wr_data (w_data),
    .i_wr_strb (w_strb),
    .i_rd_addr (rd_addr[4:2]),
    .o_rd_data (mem_rd_data),
    .i_rb_addr (budget_data_select[2:0]),
    .o_rb_data (mem_rb_data)
  );

  // ---------------------------------------------------------------
  // status word assembly, reserved bits zero
  // ---------------------------------------------------------------
  wire [31:0] status_word = {marker, 5'h00, upstream_lock_state, 10'h000,
                             hold_strap, refclk_mode, smb_slow, us_clk,
                             ds_clk, 2'b00, op_mode};

  // ---------------------------------------------------------------
  // read channel: address registered, data two cycles later
  // ---------------------------------------------------------------
  // two-stage read lets the store's registered data settle first
  reg rd_stage;
  assign o_s_axi_arready = !rd_pend && !o_s_axi_rvalid;

  // byte address bits 1:0 are dropped on capture, so an unaligned
  // read returns the whole aligned word
  wire rd_budget = (rd_addr >= `SSP_OFF_BUDGET_BASE) &&
                   (rd_addr <= `SSP_OFF_BUDGET_LAST);
  reg [31:0] rd_word;
  reg        rd_ok;
  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (rd_budget) begin
      rd_word = mem_rd_data;
    end else begin
      case (rd_addr)
        `SSP_OFF_STATUS:        rd_word = status_word;
        `SSP_OFF_CONTROL:       rd_word = {27'h0, budget_value_unlock,
                                          1'b0, hold_ctl, 2'b00};
        `SSP_OFF_BUDGET_SELECT: rd_word = {24'h0, budget_data_select};
        `SSP_OFF_BUDGET_READ: begin
          if (budget_data_select <= `SSP_SELECT_MAX) begin
            rd_word = mem_rb_data;
          end else begin
            rd_word = 32'h0000_0000;
          end
        end
        `SSP_OFF_LOCK:          rd_word = {29'h0, upstream_lock_state};
        default:                rd_ok = 1'b0;
      endcase
    end
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rd_pend        <= 1'b0;
      rd_stage       <= 1'b0;
      rd_addr        <= 12'h000;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h0000_0000;
      o_s_axi_rresp  <= `SSP_RESP_OKAY;
    end else begin
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        rd_pend  <= 1'b1;
        rd_stage <= 1'b0;
        rd_addr  <= {i_s_axi_araddr[11:2], 2'b00};
      end else if (rd_pend && !rd_stage) begin
        rd_stage <= 1'b1;
      end else if (rd_pend) begin
        rd_pend        <= 1'b0;
        rd_stage       <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata  <= rd_word;
        o_s_axi_rresp  <= rd_ok ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// [ssp_consts.vh]
// constants for the switch status and power budget register bank
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SSP_OFF_BUDGET_BASE    12'h300
`define SSP_OFF_BUDGET_LAST    12'h31c
`define SSP_OFF_BUDGET_SELECT  12'h284
`define SSP_OFF_BUDGET_READ    12'h288
`define SSP_OFF_STATUS         12'h400
`define SSP_OFF_CONTROL        12'h404
`define SSP_OFF_LOCK           12'h408

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SSP_MODE_LSB           0
`define SSP_MODE_MSB           2
`define SSP_DS_CLK_BIT         5
`define SSP_US_CLK_BIT         6
`define SSP_SMB_SLOW_BIT       7
`define SSP_REFCLK_BIT         8
`define SSP_HOLD_BIT           9
`define SSP_LOCK_LSB           20
`define SSP_LOCK_MSB           22
`define SSP_MARKER_LSB         28
`define SSP_MARKER_MSB         31
`define SSP_UNLOCK_BIT         4
`define SSP_BUDGET_COUNT       8

// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define SSP_MARKER_RESET       4'h0
`define SSP_LOCK_RESET         3'h0
`define SSP_LOCK_PORT2         3'h2
`define SSP_LOCK_PORT4         3'h4
`define SSP_SELECT_RESET       8'h00
`define SSP_SELECT_MAX         8'h07
`define SSP_RESP_OKAY          2'b00
`define SSP_RESP_SLVERR        2'b10

`endif

// [ssp_budget_mem.v]
// eight-word power budget value store with registered read data
`timescale 1ns/10ps
module ssp_budget_mem (
  // clock
  input  wire        i_clock,
  // write port
  input  wire        i_wr_en,
  input  wire [2:0]  i_wr_addr,
  input  wire [31:0] i_wr_data,
  input  wire [3:0]  i_wr_strb,
  // read ports
  input  wire [2:0]  i_rd_addr,
  output reg  [31:0] o_rd_data,
  input  wire [2:0]  i_rb_addr,
  output reg  [31:0] o_rb_data
);

  reg [31:0] mem [0:7];
  integer    b;

  // ---------------------------------------------------------------
  // storage; contents undefined at power-up and kept over resets
  // ---------------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_wr_en) begin
      for (b = 0; b < 4; b = b + 1) begin
        if (i_wr_strb[b]) begin
          mem[i_wr_addr][b*8 +: 8] <= i_wr_data[b*8 +: 8];
        end
      end
    end
    o_rd_data <= mem[i_rd_addr];
    o_rb_data <= mem[i_rb_addr];
  end

endmodule

// [ssp_regs_props.sv]
// bus handshake and hold output checker for the register bank
`timescale 1ns/10ps
module ssp_regs_props (
  // clock, reset, hold
  input logic        i_clock,
  input logic        i_rst,
  input logic        i_hold_strap,
  input logic        o_core_hold,
  // write side
  input logic        i_s_axi_awvalid, o_s_axi_awready,
  input logic        i_s_axi_wvalid, o_s_axi_wready,
  input logic [1:0]  o_s_axi_bresp,
  input logic        o_s_axi_bvalid, i_s_axi_bready,
  // read side
  input logic        i_s_axi_arvalid, o_s_axi_arready,
  input logic [31:0] o_s_axi_rdata,
  input logic        o_s_axi_rvalid, i_s_axi_rready
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // answers stand until taken
  bresp_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready
    |=> o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("bresp moved");
  rdata_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("rdata moved");
  b_done_a: assert property (o_s_axi_bvalid && i_s_axi_bready
    |=> !o_s_axi_bvalid) else $error("bvalid stuck");
  // bounded answer times
  wr_answer_a: assert property (i_s_axi_awvalid && o_s_axi_awready &&
    i_s_axi_wvalid && o_s_axi_wready |-> ##[1:4] o_s_axi_bvalid)
    else $error("no write answer");
  rd_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready
    |-> ##[2:5] o_s_axi_rvalid) else $error("no read answer");
  // one of each kind in flight; hold output follows the hold strap at reset exit
  rd_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken while busy");
  wr_block_a: assert property (i_s_axi_awvalid && o_s_axi_awready
    |=> !o_s_axi_awready) else $error("write address taken twice");
  hold_strap_a: assert property ($fell(i_rst)
    |-> o_core_hold == $past(i_hold_strap)) else $error("hold mismatch");
endmodule
bind ssp_regs ssp_regs_props u_props (.i_clock, .i_rst, .i_hold_strap,
  .o_core_hold, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid,
  .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
  .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rvalid,
  .i_s_axi_rready);

// [ssp_regs_tb.sv]
// self-checking bench for the status and budget register bank
`timescale 1ns/10ps
module ssp_regs_tb;
  // --------
  // signals
  // --------
  reg         i_clock, i_rst, i_hot_rst, ds, us, smb, rfc, hld;
  reg  [2:0]  mode, lock;
  reg  [11:0] awaddr, araddr;
  reg  [31:0] wdata;
  reg  [3:0]  wstrb;
  reg         awvalid, wvalid, bready, arvalid, rready;
  wire        hold, awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     n_errors, n_tests, i;
  integer     cyc = 0;
  reg  [93:0] rows [0:9];

  ssp_regs u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_hot_rst(i_hot_rst),
    .i_mode_pins(mode), .i_ds_clk_strap(ds), .i_us_clk_strap(us),
    .i_smb_slow_strap(smb), .i_refclk_strap(rfc), .i_hold_strap(hld),
    .i_lock_state(lock), .o_core_hold(hold), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready));

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  // watchdog: a hung handshake ends the run as a mismatch
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      conclude;
    end
  end

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task conclude;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  // ready sampled at negedge: it is settled there and equals what the
  // next rising edge sees, so no race with the design's own updates
  task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    reg ga, gw;
    integer k;
    begin
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      ga = 1'b0;
      gw = 1'b0;
      for (k = 0; k < 40 && !(ga && gw); k = k + 1) begin
        @(negedge i_clock);
        ga = ga | (awvalid & awready);
        gw = gw | (wvalid & wready);
        @(posedge i_clock);
        if (ga) awvalid <= 1'b0;
        if (gw) wvalid <= 1'b0;
      end
      k = 0;
      do begin @(negedge i_clock); k = k + 1; end while (!bvalid && k < 40);
      @(posedge i_clock);
      bready <= 1'b1; // one stall cycle before taking it
      @(negedge i_clock);
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge i_clock);
      bready <= 1'b0;
    end
  endtask

  task rd(input [11:0] a, input [31:0] e, input [1:0] er);
    integer k;
    begin
      araddr <= a;
      arvalid <= 1'b1;
      k = 0;
      do begin @(negedge i_clock); k = k + 1; end while (!arready && k < 40);
      @(posedge i_clock);
      arvalid <= 1'b0;
      k = 0;
      do begin @(negedge i_clock); k = k + 1; end while (!rvalid && k < 40);
      @(posedge i_clock);
      rready <= 1'b1;
      @(negedge i_clock);
      chk({30'h0, rresp}, {30'h0, er});
      if (er == 2'b00) chk(rdata, e);
      @(posedge i_clock);
      rready <= 1'b0;
    end
  endtask

  initial begin
    n_errors = 0;
    n_tests = 0;
    {i_rst, i_hot_rst, mode, lock} = 8'h88;
    {ds, us, smb, rfc, hld} = 5'b10101;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    // write addr, data, strobe, read addr, expected, response
    rows[0] = {12'h404, 32'h14, 4'h1, 12'h400, 32'h2a1, 2'h0};
    rows[1] = {12'h300, 32'ha5a50001, 4'hf, 12'h300, 32'ha5a50001, 2'h0};
    rows[2] = {12'h31c, 32'h5a5a0007, 4'hf, 12'h31c, 32'h5a5a0007, 2'h0};
    rows[3] = {12'h304, 32'h12345678, 4'hf, 12'h304, 32'h12345678, 2'h0};
    rows[4] = {12'h304, 32'hffffffff, 4'h2, 12'h304, 32'h1234ff78, 2'h0};
    rows[5] = {12'h400, 32'hffffffff, 4'hf, 12'h400, 32'hf00002a1, 2'h0};
    rows[6] = {12'h284, 32'h1, 4'h1, 12'h288, 32'h1234ff78, 2'h0};
    rows[7] = {12'h284, 32'h8, 4'h1, 12'h288, 32'h0, 2'h0};
    rows[8] = {12'h284, 32'h7, 4'h1, 12'h288, 32'h5a5a0007, 2'h0};
    rows[9] = {12'h500, 32'hffffffff, 4'hf, 12'h500, 32'h0, 2'h2};
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    chk({31'h0, hold}, 32'h1);
    @(posedge i_clock);
    ds <= 1'b0; // straps move after capture
    mode <= 3'h0;
    for (i = 0; i < 10; i = i + 1) begin
      wr(rows[i][93:82], rows[i][81:50], rows[i][49:46], rows[i][1:0]);
      rd(rows[i][45:34], rows[i][33:2], rows[i][1:0]);
    end
    $display("table done");
    wr(12'h404, 32'h0, 4'h1, 2'h0);
    rd(12'h404, 32'h0, 2'h0);
    chk({31'h0, hold}, 32'h0);
    wr(12'h300, 32'hdeadbeef, 4'hf, 2'h0);
    rd(12'h300, 32'ha5a50001, 2'h0);
    for (i = 4; i >= 0; i = i - 2) begin
      lock <= i[2:0];
      repeat (2) @(posedge i_clock);
      rd(12'h400, {4'hf, 5'h0, i[2:0], 20'h2a1}, 2'h0);
      rd(12'h408, {29'h0, i[2:0]}, 2'h0);
    end
    $display("lock done");
    i_hot_rst <= 1'b1;
    repeat (4) @(posedge i_clock);
    i_hot_rst <= 1'b0;
    @(posedge i_clock);
    rd(12'h400, 32'hf00002a1, 2'h0);
    rd(12'h288, 32'ha5a50001, 2'h0);
    $display("hot reset done");
    i_rst <= 1'b1;
    {ds, us, smb, rfc, hld} <= 5'b01010;
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    chk({31'h0, hold}, 32'h0);
    @(posedge i_clock);
    rd(12'h400, 32'h140, 2'h0);
    $display("reset done");
    conclude;
  end
endmodule
